// ===== logic/ssc_top.sv
/*
 Standby and subclock controller: STOP mode hold and wake settling, and the
 switch of the system clock between main clock and subclock.
 Assumes a classic Wishbone master and a one-cycle sub_tick per subclock edge.
*/
// Added by the designer: the Wishbone slave port and the register offsets.
// Overview of operation
// - During STOP, port pins keep the level they had at entry.
// - During STOP, CPU, RAM and internal state are frozen and kept.
// - Interrupt wake waits the settle time chosen in the select setting.
// - Reset wake waits the settle time of the select reset value.
// - Writing subclock_select as 1 in normal mode enters subclock mode.
// - Entering subclock mode moves the system clock from main to subclock.
// - Writing main_osc_stop as 1 halts the main oscillator.
// - Clearing subclock_select or any reset leaves subclock mode.
// - Leaving subclock mode returns the system clock to the main clock.
`default_nettype none
`include "ssc_map.svh"

module ssc_top #(
	parameter int SETTLE_BASE = `SSC_SETTLE_BASE
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Power mode requests.
	input wire logic stop_request,
	input wire logic wake_irq,
	input wire logic [2:0] settle_sel_reset_value,
	// Subclock edge marker.
	input wire logic sub_tick,
	// Clock and hold controls.
	output logic main_osc_en,
	output logic main_gate_en,
	output logic sub_gate_en,
	output logic cpu_run,
	output logic port_hold,
	output logic [2:0] clock_divider_select
);
	logic [7:0] clkc_reg, clkc_next;
	logic [2:0] settle_sel_reg, settle_sel_next;
	logic [2:0] settle_rst_reg, settle_rst_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	ssc_pkg::ssc_pwr_t pwr_reg, pwr_next;
	ssc_pkg::ssc_sw_t sw_reg, sw_next;
	logic rst_wake_reg, rst_wake_next;
	logic tmr_start, tmr_busy, tmr_done;
	logic [`SSC_CNT_W-1:0] tmr_cycles;
	logic subsel;
	logic mosc_stop;

	// Settle length for a select value; shared by reset and interrupt wake.
	function automatic logic [`SSC_CNT_W-1:0] settle_cycles(input logic [2:0] sel);
		settle_cycles = `SSC_CNT_W'(SETTLE_BASE) << sel;
	endfunction

	assign subsel = clkc_reg[`SSC_CLK_SUBSEL_BIT];
	assign mosc_stop = clkc_reg[`SSC_CLK_MOSC_BIT];

	// Bus slave and registers.
	always_comb begin
		clkc_next = clkc_reg;
		settle_sel_next = settle_sel_reg;
		settle_rst_next = settle_rst_reg;
		ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
		dat_next = dat_reg;
		if (rst_wake_reg) begin
			settle_sel_next = settle_rst_reg;
		end
		if (ack_next) begin
			unique case (wb_adr_i)
				`SSC_CLK_ADDR: dat_next = {24'h000000, clkc_reg};
				`SSC_SETTLE_ADDR: dat_next = {29'h0, settle_sel_reg};
				`SSC_STATUS_ADDR: begin
					dat_next = 32'h00000000;
					dat_next[`SSC_ST_SUBMODE_BIT] = (sw_reg == ssc_pkg::SW_SUB);
					dat_next[`SSC_ST_MOSC_BIT] = main_osc_en;
					dat_next[`SSC_ST_SETTLE_BIT] = (pwr_reg == ssc_pkg::PWR_SETTLE);
					dat_next[`SSC_ST_STOP_BIT] = (pwr_reg == ssc_pkg::PWR_STOP);
					dat_next[`SSC_ST_ONSUB_BIT] = sub_gate_en;
				end
				default: dat_next = 32'h00000000;
			endcase
		end
		// Writes take effect at the edge on which ack is seen high.
		if (ack_reg && wb_we_i && wb_sel_i[0]) begin
			unique case (wb_adr_i)
				`SSC_CLK_ADDR: begin
					// Divider bits are stored as written; keeping them is software's job.
					clkc_next[`SSC_CLK_DIV_MSB:`SSC_CLK_DIV_LSB] =
						wb_dat_i[`SSC_CLK_DIV_MSB:`SSC_CLK_DIV_LSB];
					clkc_next[`SSC_CLK_SUBSEL_BIT] = wb_dat_i[`SSC_CLK_SUBSEL_BIT];
					clkc_next[`SSC_CLK_MOSC_BIT] = wb_dat_i[`SSC_CLK_MOSC_BIT];
				end
				`SSC_SETTLE_ADDR: settle_sel_next = wb_dat_i[`SSC_SETTLE_MSB:`SSC_SETTLE_LSB];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			clkc_reg <= `SSC_CLK_RESET;
			settle_sel_reg <= 3'h0;
			settle_rst_reg <= settle_sel_reset_value;
			ack_reg <= 1'b0;
			dat_reg <= 32'h00000000;
		end else begin
			clkc_reg <= clkc_next;
			settle_sel_reg <= settle_sel_next;
			settle_rst_reg <= settle_rst_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// STOP entry and wake sequencing.
	always_comb begin
		pwr_next = pwr_reg;
		rst_wake_next = 1'b0;
		tmr_start = 1'b0;
		tmr_cycles = settle_cycles(settle_sel_reg);
		if (rst_wake_reg) begin
			tmr_start = 1'b1;
			tmr_cycles = settle_cycles(settle_rst_reg);
		end
		unique case (pwr_reg)
			ssc_pkg::PWR_SETTLE: begin
				if (tmr_done) begin
					pwr_next = ssc_pkg::PWR_RUN;
				end
			end
			ssc_pkg::PWR_RUN: begin
				if (stop_request) begin
					pwr_next = ssc_pkg::PWR_STOP;
				end
			end
			ssc_pkg::PWR_STOP: begin
				if (wake_irq) begin
					tmr_start = 1'b1;
					pwr_next = ssc_pkg::PWR_SETTLE;
				end
			end
			// The fourth code is unused; it moves to settle without starting a new settle wait.
			default: pwr_next = ssc_pkg::PWR_SETTLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pwr_reg <= ssc_pkg::PWR_SETTLE;
			rst_wake_reg <= 1'b1;
		end else begin
			pwr_reg <= pwr_next;
			rst_wake_reg <= rst_wake_next;
		end
	end

	ssc_settle_timer ssc_settle_timer_inst (
		.clock(clock),
		.reset(reset),
		.start(tmr_start),
		.cycles(tmr_cycles),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Clock source switch. Except on reset, both gates are off for at least one cycle and the
	// subclock gate only changes on a subclock edge, so no runt pulse escapes.
	always_comb begin
		sw_next = sw_reg;
		unique case (sw_reg)
			ssc_pkg::SW_MAIN: begin
				if (subsel && pwr_reg == ssc_pkg::PWR_RUN) begin
					sw_next = ssc_pkg::SW_TO_SUB;
				end
			end
			ssc_pkg::SW_TO_SUB: begin
				if (!subsel) begin
					sw_next = ssc_pkg::SW_MAIN;
				end else if (sub_tick) begin
					sw_next = ssc_pkg::SW_SUB;
				end
			end
			ssc_pkg::SW_SUB: begin
				if (!subsel && sub_tick) begin
					sw_next = ssc_pkg::SW_TO_MAIN;
				end
			end
			ssc_pkg::SW_TO_MAIN: begin
				sw_next = ssc_pkg::SW_MAIN;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			sw_reg <= ssc_pkg::SW_MAIN;
		end else begin
			sw_reg <= sw_next;
		end
	end

	// The oscillator stays off through STOP and on request in either clock mode;
	// after STOP the settle wait restarts it before anything runs again; clearing the request restarts it with no settle wait.
	assign main_osc_en = (pwr_reg != ssc_pkg::PWR_STOP) && !mosc_stop;
	assign main_gate_en = (sw_reg == ssc_pkg::SW_MAIN);
	assign sub_gate_en = (sw_reg == ssc_pkg::SW_SUB);
	assign cpu_run = (pwr_reg == ssc_pkg::PWR_RUN) && !tmr_busy;
	assign port_hold = (pwr_reg == ssc_pkg::PWR_STOP);
	assign clock_divider_select = clkc_reg[`SSC_CLK_DIV_MSB:`SSC_CLK_DIV_LSB];
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
endmodule

`default_nettype wire

// ===== logic/ssc_map.svh
/*
 Register offsets, field positions, reset values and timing figures of the
 standby and subclock controller. Assumes a 32-bit classic Wishbone slave.
*/
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// Byte addresses of the registers.
`define SSC_CLK_ADDR 8'h00
`define SSC_SETTLE_ADDR 8'h04
`define SSC_STATUS_ADDR 8'h08

// Processor clock control fields.
`define SSC_CLK_DIV_LSB 0
`define SSC_CLK_DIV_MSB 2
`define SSC_CLK_SUBSEL_BIT 3
`define SSC_CLK_MOSC_BIT 6
`define SSC_CLK_RESET 8'h00

// Settle time select field.
`define SSC_SETTLE_LSB 0
`define SSC_SETTLE_MSB 2

// Status fields.
`define SSC_ST_SUBMODE_BIT 0
`define SSC_ST_MOSC_BIT 1
`define SSC_ST_SETTLE_BIT 2
`define SSC_ST_STOP_BIT 3
`define SSC_ST_ONSUB_BIT 4

// Settle time is base cycles shifted left by the select value.
`define SSC_SETTLE_BASE 256
`define SSC_CNT_W 20

`endif

// ===== logic/ssc_pkg.sv
/*
 Types of the standby and subclock controller.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package ssc_pkg;
	typedef enum logic [1:0] {
		PWR_SETTLE,
		PWR_RUN,
		PWR_STOP
	} ssc_pwr_t;

	typedef enum logic [1:0] {
		SW_MAIN,
		SW_TO_SUB,
		SW_SUB,
		SW_TO_MAIN
	} ssc_sw_t;
endpackage

`default_nettype wire

// ===== logic/ssc_settle_timer.sv
/*
 Down counter timing the oscillator settling wait.
 Assumes the load value is stable while start is high.
*/
`default_nettype none
`include "ssc_map.svh"

module ssc_settle_timer (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Control.
	input wire logic start,
	input wire logic [`SSC_CNT_W-1:0] cycles,
	// Status.
	output logic busy,
	output logic done
);
	logic [`SSC_CNT_W-1:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;

	always_comb begin
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		if (start) begin
			cnt_next = cycles;
			busy_next = 1'b1;
		end else if (busy_reg) begin
			if (cnt_reg <= `SSC_CNT_W'(1)) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - `SSC_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	assign busy = busy_reg;
	assign done = done_reg;
endmodule

`default_nettype wire

// ===== test/ssc_props.sv
/*
 Port checker of the standby and subclock controller.
 Assumes it is bound into ssc_top with SETTLE_BASE of at least 4.
*/
`default_nettype none

module ssc_props #(
	parameter int SETTLE_BASE = 4
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic reset,
	// Bus.
	input wire logic wb_ack_o,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	// Power and clock.
	input wire logic stop_request,
	input wire logic wake_irq,
	input wire logic sub_tick,
	input wire logic main_osc_en,
	input wire logic main_gate_en,
	input wire logic sub_gate_en,
	input wire logic cpu_run,
	input wire logic port_hold
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	logic clkc_wr;
	assign clkc_wr = wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
	a_gates_apart: assert property (!(main_gate_en && sub_gate_en))
		else $error("both clock gates open");
	a_stop_entry: assert property (stop_request && cpu_run |=> port_hold && !cpu_run)
		else $error("stop not entered");
	a_hold_kept: assert property (port_hold && !wake_irq |=> port_hold)
		else $error("hold lost in stop");
	a_wake_settle: assert property (port_hold && wake_irq |=> !port_hold ##1 !cpu_run[*3])
		else $error("wake too early");
	a_reset_settle: assert property ($fell(reset) |-> !cpu_run[*4])
		else $error("reset wake too early");
	a_sub_on: assert property ($rose(sub_gate_en) |-> $past(sub_tick))
		else $error("subclock gate off edge");
	a_sub_off: assert property ($fell(sub_gate_en) |-> $past(sub_tick))
		else $error("subclock gate cut off edge");
	a_main_gap: assert property ($rose(main_gate_en) |-> !$past(sub_gate_en))
		else $error("no gap before main");
	a_osc_halt: assert property (clkc_wr && wb_dat_i[6] |=> !main_osc_en)
		else $error("main oscillator runs");
	a_sub_entry: assert property (clkc_wr && wb_dat_i[3] && cpu_run |-> ##[1:2] !main_gate_en)
		else $error("main gate stays open");
endmodule

bind ssc_top ssc_props #(.SETTLE_BASE(SETTLE_BASE)) ssc_props_inst (
	.clock(clock),
	.reset(reset),
	.wb_ack_o(wb_ack_o),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.stop_request(stop_request),
	.wake_irq(wake_irq),
	.sub_tick(sub_tick),
	.main_osc_en(main_osc_en),
	.main_gate_en(main_gate_en),
	.sub_gate_en(sub_gate_en),
	.cpu_run(cpu_run),
	.port_hold(port_hold)
);

`default_nettype wire

// ===== test/ssc_top_tb.sv
/*
 Self-checking bench of the standby and subclock controller.
 Assumes the design files and the checker are compiled before it.
*/
`default_nettype none

module ssc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BASE = 4;
	logic clock = 0, reset = 1, cyc = 0, stb = 0, we = 0;
	logic stop_request = 0, wake_irq = 0, sub_tick = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dat;
	logic [2:0] strap = 3'h1, div;
	logic ack, osc, mgate, sgate, run, hold;
	int error_cnt = 0, cmp_count = 0, n;
	ssc_top #(.SETTLE_BASE(BASE)) ssc_top_inst (.clock(clock), .reset(reset),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .stop_request(stop_request),
		.wake_irq(wake_irq), .settle_sel_reset_value(strap), .sub_tick(sub_tick),
		.main_osc_en(osc), .main_gate_en(mgate), .sub_gate_en(sgate), .cpu_run(run),
		.port_hold(hold), .clock_divider_select(div));
	always #5 clock = ~clock;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		{cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'h1, d};
		do @(posedge clock); while (ack !== 1'b1);
		dat = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	// Cycles until the core runs again must lie in the settle window.
	task settle(input int lo);
		n = 0;
		while (run !== 1'b1) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, n >= lo && n <= lo + 3}, 32'h1);
	endtask
	task tick();
		@(posedge clock) sub_tick <= 1'b1;
		@(posedge clock) sub_tick <= 1'b0;
		repeat (3) @(posedge clock);
	endtask
	task t_boot();
		settle(BASE << 1);
		wb(1'b0, 8'h04, 32'h0);
		chk(dat, 32'h1);
		wb(1'b1, 8'h00, 32'h5);
		wb(1'b0, 8'h00, 32'h0);
		chk(dat, 32'h5);
		wb(1'b0, 8'h0c, 32'h0);
		chk(dat, 32'h0);
		$display("t_boot done");
	endtask
	task t_stop();
		wb(1'b1, 8'h04, 32'h2);
		@(posedge clock) stop_request <= 1'b1;
		@(posedge clock) stop_request <= 1'b0;
		repeat (20) @(posedge clock);
		chk({hold, run, div}, {2'b10, 3'h5});
		wb(1'b0, 8'h08, 32'h0);
		chk(dat, 32'h8);
		@(posedge clock) wake_irq <= 1'b1;
		@(posedge clock) wake_irq <= 1'b0;
		settle(BASE << 2);
		chk({31'h0, hold}, 32'h0);
		$display("t_stop done");
	endtask
	task t_sub();
		wb(1'b1, 8'h00, 32'h0d);
		repeat (3) @(posedge clock);
		chk({mgate, sgate}, 2'b00);
		tick();
		chk({mgate, sgate}, 2'b01);
		wb(1'b0, 8'h08, 32'h0);
		chk(dat, 32'h13);
		wb(1'b1, 8'h00, 32'h4d);
		@(posedge clock);
		chk({31'h0, osc}, 32'h0);
		wb(1'b1, 8'h00, 32'h0d);
		repeat (40) @(posedge clock);
		wb(1'b1, 8'h00, 32'h05);
		tick();
		chk({osc, mgate, sgate, div}, {3'b110, 3'h5});
		wb(1'b1, 8'h00, 32'h0d);
		tick();
		@(posedge clock) reset <= 1'b1;
		repeat (3) @(posedge clock);
		chk({mgate, sgate}, 2'b10);
		reset <= 1'b0;
		settle(BASE << 1);
		$display("t_sub done");
	endtask
	task print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		t_boot();
		t_stop();
		t_sub();
		print_verdict();
	end
endmodule

`default_nettype wire
